// *** rtl/seefe_top.sv ***
// Serial front end of a 64K x 8 EEPROM acting as an SPI slave.
`timescale 1ns/1ps
module seefe_top
  import seefe_pkg::*;
(
  // System clock and reset.
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Serial link pins.
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_mosi,
  input  wire logic i_hold_n,
  output logic      o_miso,
  output logic      o_miso_oe,
  // Power state.
  output logic      o_active
);

  // Link domain state, clocked by the serial clock.
  seefe_phase_t            phase;
  logic [2:0]              bcnt;
  logic [6:0]              rx;
  logic                    abyte;
  logic                    is_read;
  logic [SEEFE_ADDR_W-1:0] addr;
  logic                    rd_tog;
  logic                    wr_tog;
  logic [SEEFE_WORD_W-1:0] wr_word;
  logic                    ok_s1;
  logic                    ok_s2;
  logic [2:0]              obit;
  logic [6:0]              out_sh;
  logic                    drive;
  logic                    paused_q;
  logic                    miso_oe_q;
  logic [SEEFE_DATA_W-1:0] byte_in;
  logic                    pause_now;

  // System domain state.
  logic                    cs_s1;
  logic                    cs_s2;
  logic                    cs_d;
  logic                    armed;
  logic                    frame_ok;
  logic                    rd_s1;
  logic                    rd_s2;
  logic                    rd_s3;
  logic                    wr_s1;
  logic                    wr_s2;
  logic                    wr_s3;
  logic                    rd_ev;
  logic                    wr_ev;
  logic                    wr_pend;
  logic [SEEFE_DATA_W-1:0] mem_rdata;

  seefe_stream_if #(.WIDTH(SEEFE_WORD_W)) fifo_in  ();
  seefe_stream_if #(.WIDTH(SEEFE_WORD_W)) fifo_out ();

  // The byte being completed by the current rising edge, most significant bit first.
  assign byte_in = {rx, i_mosi};

  // Rising edge capture: instruction, then address, then write data.
  // Deselect clears everything at once, paused or not.
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      phase   <= SEEFE_PH_INSTR;
      bcnt    <= SEEFE_BIT_FIRST;
      rx      <= '0;
      abyte   <= SEEFE_ABYTE_HIGH;
      is_read <= 1'b0;
      addr    <= '0;
      rd_tog  <= 1'b0;
      wr_tog  <= 1'b0;
    end else if (i_hold_n) begin
      rx   <= byte_in[6:0];
      bcnt <= bcnt + 1'b1;
      case (phase)
        SEEFE_PH_INSTR: begin
          if (bcnt == SEEFE_BIT_LAST) begin
            is_read <= (byte_in == SEEFE_CMD_READ);
            if (!ok_s2) begin
              phase <= SEEFE_PH_IGNORE;
            end else if (byte_in == SEEFE_CMD_READ || byte_in == SEEFE_CMD_WRITE) begin
              phase <= SEEFE_PH_ADDR;
            end else begin
              phase <= SEEFE_PH_IGNORE;
            end
          end
        end
        SEEFE_PH_ADDR: begin
          addr <= {addr[SEEFE_ADDR_W-2:0], i_mosi};
          if (bcnt == SEEFE_BIT_LAST) begin
            abyte <= SEEFE_ABYTE_LOW;
            if (abyte == SEEFE_ABYTE_LOW) begin
              if (is_read) begin
                phase  <= SEEFE_PH_READ;
                rd_tog <= !rd_tog;
              end else begin
                phase <= SEEFE_PH_WRITE;
              end
            end
          end
        end
        SEEFE_PH_READ: begin
          // Fetch the following byte halfway through the current one.
          if (bcnt == SEEFE_BIT_PREFETCH) begin
            addr   <= addr + 1'b1;
            rd_tog <= !rd_tog;
          end
        end
        SEEFE_PH_WRITE: begin
          if (bcnt == SEEFE_BIT_LAST) begin
            addr   <= addr + 1'b1;
            wr_tog <= !wr_tog;
          end
        end
        default: begin
          phase <= SEEFE_PH_IGNORE;
        end
      endcase
    end
  end

  // Completed write byte with its address, held until the next byte completes.
  always_ff @(posedge i_sck) begin
    if (!i_cs_n && i_hold_n && phase == SEEFE_PH_WRITE && bcnt == SEEFE_BIT_LAST) begin
      wr_word <= {addr, byte_in};
    end
  end

  // Frame permission from the system domain, brought over by two flip-flops.
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      ok_s1 <= 1'b0;
      ok_s2 <= 1'b0;
    end else begin
      ok_s1 <= frame_ok;
      ok_s2 <= ok_s1;
    end
  end

  // Falling edge shift out of read data.
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_miso   <= 1'b0;
      out_sh   <= '0;
      obit     <= SEEFE_BIT_FIRST;
      drive    <= 1'b0;
    end else begin
      if (i_hold_n && phase == SEEFE_PH_READ) begin
        drive <= 1'b1;
        obit  <= obit + 1'b1;
        if (obit == SEEFE_BIT_FIRST) begin
          o_miso <= mem_rdata[SEEFE_DATA_W-1];
          out_sh <= mem_rdata[SEEFE_DATA_W-2:0];
        end else begin
          o_miso <= out_sh[6];
          out_sh <= {out_sh[5:0], 1'b0};
        end
      end
    end
  end

  // The pause pin as it stood while the clock was low is held through the high half.
  // Taking it at the falling edge instead would unpause a pause begun while low.
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      paused_q <= 1'b0;
    end else begin
      paused_q <= !i_hold_n;
    end
  end

  // While the clock is low the pause follows the pin; while high it holds the value taken.
  assign pause_now = i_sck ? paused_q : !i_hold_n;

  // Output enable: selected, not paused and in the read phase.
  assign miso_oe_q = drive && !pause_now && !i_cs_n;
  assign o_miso_oe = miso_oe_q;

  // Select line into the system clock, two flip-flops then an edge history.
  // These run through reset so that at release they show the real pin; a forced high
  // here would arm a frame whose select was already low.
  always_ff @(posedge i_clk) begin
    cs_s1 <= i_cs_n;
    cs_s2 <= cs_s1;
    cs_d  <= cs_s2;
  end

  // A frame is allowed only if select was seen high before it fell.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      armed    <= 1'b0;
      frame_ok <= 1'b0;
    end else begin
      if (cs_s2) begin
        armed <= 1'b1;
      end
      if (cs_s2) begin
        frame_ok <= 1'b0;
      end else if (cs_d) begin
        frame_ok <= armed;
      end
    end
  end

  // Read and write event toggles into the system clock.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
      rd_s3 <= 1'b0;
      wr_s1 <= 1'b0;
      wr_s2 <= 1'b0;
      wr_s3 <= 1'b0;
    end else begin
      rd_s1 <= rd_tog;
      rd_s2 <= rd_s1;
      rd_s3 <= rd_s2;
      wr_s1 <= wr_tog;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
    end
  end

  assign rd_ev = rd_s2 ^ rd_s3;
  assign wr_ev = wr_s2 ^ wr_s3;

  // A write word waits here until the FIFO takes it; a new event wins over the take.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_pend <= 1'b0;
    end else if (wr_ev) begin
      wr_pend <= 1'b1;
    end else if (fifo_in.ready) begin
      wr_pend <= 1'b0;
    end
  end

  // The word register is stable for a whole serial byte after its event.
  assign fifo_in.valid = wr_pend;
  assign fifo_in.data  = wr_word;

  // Reads take the array first; the FIFO drains in every cycle without a read event.
  assign fifo_out.ready = !rd_ev;

  seefe_fifo #(
    .WIDTH (SEEFE_WORD_W),
    .DEPTH (SEEFE_FIFO_DEPTH)
  ) u_fifo (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .s_in     (fifo_in.snk),
    .s_out    (fifo_out.src)
  );

  seefe_mem u_mem (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_re     (rd_ev),
    .i_we     (fifo_out.valid && !rd_ev),
    .i_addr   (rd_ev ? addr : fifo_out.data[SEEFE_WORD_W-1:SEEFE_DATA_W]),
    .i_wdata  (fifo_out.data[SEEFE_DATA_W-1:0]),
    .o_rdata  (mem_rdata)
  );

  // Active while selected or while any write is still on its way to the array.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_active <= 1'b0;
    end else begin
      o_active <= !cs_s2 || wr_pend || fifo_out.valid;
    end
  end

endmodule

// *** shared/seefe_pkg.sv ***
// Constants, field widths and types shared by the serial EEPROM front end.
package seefe_pkg;

  // Storage array geometry.
  localparam int SEEFE_ADDR_W     = 16;
  localparam int SEEFE_DATA_W     = 8;
  localparam int SEEFE_MEM_DEPTH  = 32'h0001_0000;

  // Write word carried to the array: address in the upper bits, data in the lower bits.
  localparam int SEEFE_WORD_W     = SEEFE_ADDR_W + SEEFE_DATA_W;
  localparam int SEEFE_FIFO_DEPTH = 4;

  // Instruction codes that this front end acts upon.
  localparam logic [7:0] SEEFE_CMD_READ  = 8'h03;
  localparam logic [7:0] SEEFE_CMD_WRITE = 8'h02;

  // Bit positions inside a byte, counted from the most significant bit.
  localparam logic [2:0] SEEFE_BIT_FIRST    = 3'h0;
  localparam logic [2:0] SEEFE_BIT_LAST     = 3'h7;
  localparam logic [2:0] SEEFE_BIT_PREFETCH = 3'h4;

  // The address arrives as a high byte followed by a low byte.
  localparam logic SEEFE_ABYTE_HIGH = 1'b0;
  localparam logic SEEFE_ABYTE_LOW  = 1'b1;

  // Phase of the current frame as seen from the serial clock.
  typedef enum logic [2:0] {
    SEEFE_PH_INSTR,
    SEEFE_PH_ADDR,
    SEEFE_PH_READ,
    SEEFE_PH_WRITE,
    SEEFE_PH_IGNORE
  } seefe_phase_t;

endpackage

// *** shared/seefe_stream_if.sv ***
// Valid and ready stream that carries write words between the front end modules.
`timescale 1ns/1ps
interface seefe_stream_if #(
  parameter int WIDTH = 24
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  // The producer drives valid and data, the consumer drives ready.
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** rtl/seefe_store.sv ***
// Write word FIFO and the byte-wide storage array of the front end.
`timescale 1ns/1ps
module seefe_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  // Filling and draining sides.
  seefe_stream_if.snk s_in,
  seefe_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Pointers carry one extra wrap bit so that full and empty differ.
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign push  = s_in.valid && !full;
  assign pop   = s_out.ready && !empty;

  assign s_in.ready  = !full;
  assign s_out.valid = !empty;
  assign s_out.data  = store[rd_ptr[AW-1:0]];

  // Pointer update on every accepted push and pop.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // One storage entry per slot, written only when the push lands on it.
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    always_ff @(posedge i_clk) begin
      if (push && (wr_ptr[AW-1:0] == AW'(g))) begin
        store[g] <= s_in.data;
      end
    end
  end
endmodule

module seefe_mem
  import seefe_pkg::*;
(
  // Clock and reset.
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  // Single access port: a read or a write in each cycle.
  input  wire logic                    i_re,
  input  wire logic                    i_we,
  input  wire logic [SEEFE_ADDR_W-1:0] i_addr,
  input  wire logic [SEEFE_DATA_W-1:0] i_wdata,
  output logic      [SEEFE_DATA_W-1:0] o_rdata
);
  logic [SEEFE_DATA_W-1:0] array_q [0:SEEFE_MEM_DEPTH-1];

  // The array holds every location of the 16-bit address space.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      array_q[i_addr] <= i_wdata;
    end
  end

  // Read data come out of a register and hold until the next read.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= array_q[i_addr];
    end
  end
endmodule

// *** verification/seefe_checker.sv ***
// Concurrent checks on the pins of the serial front end.
`timescale 1ns/1ps
module seefe_checker (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Serial link pins.
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_hold_n,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  // Power state.
  input wire logic o_active
);
  logic [6:0] desel_cnt;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // Counts cycles spent deselected, saturating so a long idle stays visible.
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_cs_n) begin
      desel_cnt <= 7'h00;
    end else if (desel_cnt != 7'h7F) begin
      desel_cnt <= desel_cnt + 7'h01;
    end
  end

  property p_oe_desel;
    i_cs_n |-> !o_miso_oe;
  endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("miso driven while deselected");
  property p_active_sel;
    (!i_cs_n) [*6] |-> o_active;
  endproperty
  a_active_sel: assert property (p_active_sel) else $error("selected but not active");
  property p_miso_edge;
    (o_miso_oe && $past(o_miso_oe) && $changed(o_miso)) |-> !i_sck;
  endproperty
  a_miso_edge: assert property (p_miso_edge) else $error("miso moved with clock high");
  property p_oe_rise;
    $rose(o_miso_oe) |-> !i_sck && !i_cs_n && i_hold_n;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("miso enable rose out of turn");
  property p_oe_drop;
    $fell(o_miso_oe) |-> i_cs_n || !i_hold_n;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("miso enable fell without cause");
  property p_hold_float;
    (!i_hold_n && !i_sck && !i_cs_n) [*2] |-> !o_miso_oe;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("miso driven while paused");
  property p_active_fall;
    $fell(o_active) |-> i_cs_n && $past(i_cs_n, 2);
  endproperty
  a_active_fall: assert property (p_active_fall) else $error("standby while selected");
  property p_standby;
    desel_cnt == 7'h7F |-> !o_active;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby after long idle");
endmodule

bind seefe_top seefe_checker u_chk (
  .i_clk     (i_clk),
  .i_resetn  (i_resetn),
  .i_sck     (i_sck),
  .i_cs_n    (i_cs_n),
  .i_mosi    (i_mosi),
  .i_hold_n  (i_hold_n),
  .o_miso    (o_miso),
  .o_miso_oe (o_miso_oe),
  .o_active  (o_active)
);

// *** verification/seefe_spi_master.sv ***
// Bus master model that drives the serial link of the front end.
`timescale 1ns/1ps
module seefe_spi_master (
  // Serial link pins toward the device.
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_mosi,
  output logic      o_hold_n,
  // Device output and its enable.
  input  wire logic i_miso,
  input  wire logic i_miso_oe
);
  logic cpol;
  logic saw_oe;

  // Idle bus: deselected, clock low, no pause.
  initial begin
    cpol = 1'h0;
    saw_oe = 1'h0;
    o_sck = 1'h0;
    o_cs_n = 1'h0;
    o_mosi = 1'h0;
    o_hold_n = 1'h1;
    // A sure rising select edge clears the link side, which has no other reset.
    #1;
    o_cs_n = 1'h1;
  end

  // Remembers whether the device drove its output in this frame.
  always @(posedge i_miso_oe) saw_oe = 1'h1;

  // Selects the device with the clock idling in the chosen mode.
  task automatic select(input logic mode);
    #7.3;
    cpol = mode;
    o_sck = mode;
    #20;
    saw_oe = 1'h0;
    o_cs_n = 1'h0;
    #25;
  endtask

  // Shifts one byte each way; a floating output reads back as z.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sck = 1'h0;
      o_mosi = tx[i];
      #40;
      o_sck = 1'h1;
      rx[i] = i_miso_oe ? i_miso : 1'bz;
      #40;
    end
    o_mosi = ~o_mosi;
  endtask

  // Pauses with the clock low and wiggles clock and data while paused.
  task automatic pause(input logic resume);
    o_sck = 1'h0;
    #20;
    o_hold_n = 1'h0;
    repeat (4) begin
      #40;
      o_sck = ~o_sck;
      o_mosi = ~o_mosi;
    end
    #40;
    if (resume) o_hold_n = 1'h1;
    #20;
  endtask

  // Returns the clock to idle, then deselects and ends any pause.
  task automatic deselect();
    o_sck = cpol;
    #20;
    o_cs_n = 1'h1;
    o_hold_n = 1'h1;
    #100;
  endtask
endmodule

// *** verification/tb_seefe_top.sv ***
// Self-checking bench of the serial EEPROM front end.
`timescale 1ns/1ps
module tb_seefe_top
  import seefe_pkg::*;
;
  logic       i_clk;
  logic       i_resetn;
  wire        sck, cs_n, mosi, hold_n, miso, miso_oe, active;
  int         n_errors = 0;
  int         compares = 0;
  int         cycles = 0;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  logic [7:0] rx;
  // Rows of mode, address and the byte written then read back.
  localparam logic [24:0] ROWS [4] = '{{1'h0, 16'h0000, 8'hA5}, {1'h1, 16'hFFFF, 8'h3C},
                                      {1'h0, 16'h1234, 8'h81}, {1'h1, 16'h8000, 8'h5A}};

  seefe_top uut (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_sck     (sck),
    .i_cs_n    (cs_n),
    .i_mosi    (mosi),
    .i_hold_n  (hold_n),
    .o_miso    (miso),
    .o_miso_oe (miso_oe),
    .o_active  (active)
  );

  seefe_spi_master u_mst (
    .o_sck     (sck),
    .o_cs_n    (cs_n),
    .o_mosi    (mosi),
    .o_hold_n  (hold_n),
    .i_miso    (miso),
    .i_miso_oe (miso_oe)
  );

  // System clock of 5 ns.
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Compares a value and counts the comparison.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Runs one frame; a pause may come before data byte stop, ended by deselect if not resumed.
  task automatic frame(input logic sel, input logic mode, input logic [7:0] cmd,
                       input logic [15:0] addr, input int n, input int stop, input logic resume);
    if (sel) begin
      u_mst.select(mode);
      chk({7'h00, active}, 8'h01);
    end
    u_mst.xfer(cmd, rx);
    u_mst.xfer(addr[15:8], rx);
    u_mst.xfer(addr[7:0], rx);
    for (int i = 0; i < n; i++) begin
      if (i == stop) begin
        u_mst.pause(resume);
        if (!resume) break;
      end
      u_mst.xfer(wbuf[i], rx);
      rbuf[i] = rx;
    end
    u_mst.deselect();
  endtask

  // Cuts a hung run short.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  // Main sequence: table rows, then bursts, pause, abort, bad code and lockout.
  initial begin
    i_resetn = 1'h0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'h1;
    repeat (8) @(posedge i_clk);
    foreach (ROWS[r]) begin
      wbuf[0] = ROWS[r][7:0];
      frame(1'h1, ROWS[r][24], SEEFE_CMD_WRITE, ROWS[r][23:8], 1, -1, 1'h1);
      frame(1'h1, ROWS[r][24], SEEFE_CMD_READ, ROWS[r][23:8], 1, -1, 1'h1);
      chk(rbuf[0], ROWS[r][7:0]);
    end
    wbuf = '{8'h11, 8'h22, 8'h33, 8'h44};
    frame(1'h1, 1'h0, SEEFE_CMD_WRITE, 16'hFFFE, 4, -1, 1'h1);
    frame(1'h1, 1'h1, SEEFE_CMD_READ, 16'hFFFE, 4, 2, 1'h1);
    for (int i = 0; i < 4; i++) chk(rbuf[i], wbuf[i]);
    wbuf[0] = 8'hEE;
    frame(1'h1, 1'h0, SEEFE_CMD_WRITE, 16'h1234, 1, 0, 1'h0);
    frame(1'h1, 1'h0, SEEFE_CMD_READ, 16'h1234, 1, -1, 1'h1);
    chk(rbuf[0], 8'h81);
    frame(1'h1, 1'h0, 8'h05, 16'h0000, 1, -1, 1'h1);
    chk({7'h00, u_mst.saw_oe}, 8'h00);
    u_mst.select(1'h0);
    @(posedge i_clk);
    i_resetn <= 1'h0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'h1;
    frame(1'h0, 1'h0, SEEFE_CMD_READ, 16'h1234, 1, -1, 1'h1);
    chk({7'h00, u_mst.saw_oe}, 8'h00);
    frame(1'h1, 1'h0, SEEFE_CMD_READ, 16'h1234, 1, -1, 1'h1);
    chk(rbuf[0], 8'h81);
    repeat (150) @(posedge i_clk);
    wrap_up();
  end
endmodule
